// File: bcs_top.sv
// Decided for this implementation: the register offsets and the plain strobed port.
`include "bcs_defs.svh"
// Overview of operation
// - each channel fresh flag is 1 after new decoded data, 0 after read.
// - each channel standstill flag: 1 standstill, 0 normal.
// - supply battery-short flag per channel, 1 when shorted while off.
// - eight-bit pulse count copy latched at select rising edge.
// - per sensor pin fault flag for open load or ground short.
// - per sensor pin overcurrent flag.
// - eight low-side enables, not cleared by output faults.
// - two lamp enables, not cleared by lamp faults.
// - main and pump relay enables cleared by their driver fault.
// - watchdog enabled: low-sides and relays off unless in range.
// - watchdog disabled: no in-range gating, low-sides 0-3 still PWM-gated, in-range reads 0.
// - overvoltage action bit: 0 keeps main relay, 1 turns it off.
// - watchdog fault latch sets when in-range drops, clears on read.
// - upper window 00/01/10/11 = 64/32/16/8 ms.
// - lower window 00/01/10/11 = 32/16/8/4 ms.
// - ten-bit duty per PWM channel, applied at next period start.
// - PWM phase offset 0, 90, 180, 270 degrees.
// - speed output enables cleared only by battery overvoltage.
// - sensor supply bits on at 1, cleared only by overvoltage.
// - sensor return bits on at 1, cleared only by overvoltage.
// - relay ground-short and overcurrent protections enabled at 1, reset 0.
// - two select bits route one sensor to the pulse counter.
// - overflow flag sets when pulse count wraps from 255 to 0.
// - conflict flag sets when count enable and clear are both set.
module bcs_top #(
	parameter int MS_CYCLES = `BCS_MS_NS / `BCS_CLK_NS
) (
	// clock and reset
	input wire logic CLK_IN,
	input wire logic RSTN_IN,
	// register port
	input wire logic [4:0] ADDR_IN,
	input wire logic [7:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	output logic [7:0] RDATA_OUT,
	// pins and decoder
	input wire bcs_pkg::bcs_pins_t PINS_IN,
	input wire bcs_pkg::bcs_dec_t DEC_IN,
	// drivers
	output logic [7:0] LOWSIDE_OUT,
	output logic [1:0] LAMP_OUT,
	output logic MR_GATE_OUT,
	output logic PR_GATE_OUT,
	output logic [1:0] SPEED_OE_OUT,
	output logic [3:0] SUPPLY_ON_OUT,
	output logic [3:0] RETURN_ON_OUT,
	output logic SENSOR_KIND_OUT,
	output logic [3:0] PROTECT_OUT
);
	bcs_pkg::bcs_pins_t s1_r, s2_r, s3_r;
	logic [7:0] ls_en_r;
	logic [7:0] misc_r, misc_nxt;
	logic [7:0] wd_cfg_r;
	logic [7:0] sens_r, sens_nxt;
	logic [7:0] sup_r, sup_nxt;
	logic [7:0] prot_r;
	logic [7:0] cctl_r;
	logic [7:0] cnt_r, cnt_nxt;
	logic [7:0] cval_r;
	logic [3:0] fresh_r;
	logic [31:0] data_r;
	logic [7:0] rdata_r;
	logic ovf_r, conf_r, wdf_r;
	logic in_range_r, in_range_nxt;
	logic [31:0] ms_cnt_r;
	logic [6:0] win_r;
	logic [2:0] pre_r;
	logic [9:0] base_r;
	logic [7:0] duty_lo_r [4];
	logic [1:0] duty_hi_r [4];
	logic [1:0] phase_r [4];
	logic [9:0] duty_act_r [4];
	logic [3:0] pwm_r;

	// decode
	wire wr_ls = WR_IN && (ADDR_IN == `BCS_A_LS);
	wire wr_misc = WR_IN && (ADDR_IN == `BCS_A_MISC);
	wire wr_wd = WR_IN && (ADDR_IN == `BCS_A_WD);
	wire wr_sens = WR_IN && (ADDR_IN == `BCS_A_SENS);
	wire wr_sup = WR_IN && (ADDR_IN == `BCS_A_SUP);
	wire wr_prot = WR_IN && (ADDR_IN == `BCS_A_PROT);
	wire wr_cctl = WR_IN && (ADDR_IN == `BCS_A_CCTL);
	wire rd_flt2 = RD_IN && (ADDR_IN == `BCS_A_FLT2);
	wire wr_dlo = WR_IN && (ADDR_IN[4:2] == 3'(`BCS_A_DLO >> 2));
	wire wr_dhi = WR_IN && (ADDR_IN[4:2] == 3'(`BCS_A_DHI >> 2));
	wire rd_data = RD_IN && (ADDR_IN[4:2] == 3'(`BCS_A_DATA >> 2));
	wire [1:0] sub = ADDR_IN[1:0];

	// synchronised pin view
	wire ov = s2_r.overvolt;
	wire sel_rise = s2_r.sel_n && !s3_r.sel_n;
	wire kick = s2_r.wd_kick && !s3_r.wd_kick;
	wire watchdog_gate_enable = misc_r[`BCS_B_WDEN];
	wire wd_ok = !watchdog_gate_enable || in_range_r;
	wire mr_fault = (s2_r.mr_gnd && prot_r[`BCS_B_MRGND])
		|| (s2_r.mr_oc && prot_r[`BCS_B_MROC]);
	wire pr_fault = (s2_r.pr_gnd && prot_r[`BCS_B_PRGND])
		|| (s2_r.pr_oc && prot_r[`BCS_B_PROC]);

	// enables with hardware clears
	always_comb begin
		misc_nxt = wr_misc ? WDATA_IN : misc_r;
		if (mr_fault)
			misc_nxt[`BCS_B_MR] = 1'b0;
		if (pr_fault)
			misc_nxt[`BCS_B_PR] = 1'b0;
		sens_nxt = wr_sens ? WDATA_IN : sens_r;
		sup_nxt = wr_sup ? WDATA_IN : sup_r;
		if (ov) begin
			sens_nxt[`BCS_B_SPD1] = 1'b0;
			sens_nxt[`BCS_B_SPD2] = 1'b0;
			sup_nxt = `BCS_RST8;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			ls_en_r <= `BCS_RST8;
			misc_r <= `BCS_RST_MISC;
			wd_cfg_r <= `BCS_RST8;
			sens_r <= `BCS_RST8;
			sup_r <= `BCS_RST8;
			prot_r <= `BCS_RST_PROT;
			cctl_r <= `BCS_RST8;
		end else begin
			if (wr_ls)
				ls_en_r <= WDATA_IN;
			misc_r <= misc_nxt;
			if (wr_wd)
				wd_cfg_r <= WDATA_IN;
			sens_r <= sens_nxt;
			sup_r <= sup_nxt;
			if (wr_prot)
				prot_r <= WDATA_IN;
			if (wr_cctl)
				cctl_r <= WDATA_IN;
		end
	end

	// pin synchroniser
	always_ff @(posedge CLK_IN) begin
		s1_r <= PINS_IN;
		s2_r <= s1_r;
		s3_r <= s2_r;
	end

	// decoded sensor words
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			fresh_r <= 4'h0;
			data_r <= 32'h0000_0000;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (DEC_IN.stb[i]) begin
					fresh_r[i] <= 1'b1;
					data_r[i*8 +: 8] <= DEC_IN.data[i*8 +: 8];
				end else if (rd_data && sub == 2'(i)) begin
					fresh_r[i] <= 1'b0;
				end
			end
		end
	end

	// pulse counter
	wire pulse_edge = s2_r.pulse[cctl_r[1:0]] && !s3_r.pulse[cctl_r[1:0]];
	wire cnt_en = cctl_r[`BCS_B_CEN];
	wire counting_clear = cctl_r[`BCS_B_CCLR];
	wire cnt_wrap = cnt_en && !counting_clear && pulse_edge && (cnt_r == 8'hff);
	assign cnt_nxt = counting_clear ? 8'h00 : (cnt_en && pulse_edge) ? 8'(cnt_r + 8'h01) : cnt_r;

	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			cnt_r <= 8'h00;
			cval_r <= 8'h00;
			ovf_r <= 1'b0;
			conf_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			if (sel_rise)
				cval_r <= cnt_r;
			if (cnt_wrap)
				ovf_r <= 1'b1;
			else if (rd_flt2)
				ovf_r <= 1'b0;
			if (cnt_en && counting_clear)
				conf_r <= 1'b1;
			else if (rd_flt2)
				conf_r <= 1'b0;
		end
	end

	// watchdog window
	wire ms_tick = (ms_cnt_r == 32'(MS_CYCLES - 1));
	wire [6:0] win_up = `BCS_WD_UP_MS >> wd_cfg_r[1:0];
	wire [6:0] win_lo = `BCS_WD_LO_MS >> wd_cfg_r[3:2];

	always_comb begin
		in_range_nxt = in_range_r;
		if (!watchdog_gate_enable)
			in_range_nxt = 1'b0;
		else if (kick)
			in_range_nxt = (win_r >= win_lo) && (win_r <= win_up);
		else if (win_r > win_up)
			in_range_nxt = 1'b0;
	end

	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			ms_cnt_r <= 32'h0000_0000;
			win_r <= 7'h00;
			in_range_r <= 1'b0;
			wdf_r <= 1'b0;
		end else begin
			ms_cnt_r <= ms_tick ? 32'h0000_0000 : ms_cnt_r + 32'h0000_0001;
			if (!watchdog_gate_enable || kick)
				win_r <= 7'h00;
			else if (ms_tick && win_r != 7'h7f)
				win_r <= win_r + 7'h01;
			in_range_r <= in_range_nxt;
			if (in_range_r && !in_range_nxt)
				wdf_r <= 1'b1;
			else if (rd_flt2)
				wdf_r <= 1'b0;
		end
	end

	// pwm time base
	wire [2:0] pre_mask = 3'((4'h1 << wd_cfg_r[5:4]) - 4'h1);
	wire pwm_tick = (pre_r & pre_mask) == pre_mask;

	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			pre_r <= 3'h0;
			base_r <= 10'h000;
		end else begin
			pre_r <= pre_r + 3'h1;
			if (pwm_tick)
				base_r <= base_r + 10'h001;
		end
	end

	generate
		for (genvar g = 0; g < 4; g++) begin : g_pwm
			wire [9:0] ph = base_r + {phase_r[g], 8'h00};
			always_ff @(posedge CLK_IN) begin
				if (!RSTN_IN) begin
					duty_lo_r[g] <= 8'h00;
					duty_hi_r[g] <= 2'h0;
					phase_r[g] <= 2'h0;
					duty_act_r[g] <= 10'h000;
					pwm_r[g] <= 1'b0;
				end else begin
					if (wr_dlo && sub == 2'(g))
						duty_lo_r[g] <= WDATA_IN;
					if (wr_dhi && sub == 2'(g)) begin
						duty_hi_r[g] <= WDATA_IN[1:0];
						phase_r[g] <= WDATA_IN[3:2];
					end
					if (pwm_tick && ph == 10'h3ff)
						duty_act_r[g] <= {duty_hi_r[g], duty_lo_r[g]};
					pwm_r[g] <= ph < duty_act_r[g];
				end
			end
		end
	endgenerate

	// read mux
	wire [7:0] stat = {DEC_IN.still, fresh_r};
	wire [7:0] flt1 = {s2_r.pin_oc, s2_r.pin_fault};
	wire [7:0] flt2 = {conf_r, ovf_r, wdf_r, in_range_r, s2_r.batt_short};
	logic [7:0] rd_mux;

	always_comb begin
		case (ADDR_IN)
			`BCS_A_LS: rd_mux = ls_en_r;
			`BCS_A_MISC: rd_mux = misc_r;
			`BCS_A_WD: rd_mux = wd_cfg_r;
			`BCS_A_SENS: rd_mux = sens_r;
			`BCS_A_SUP: rd_mux = sup_r;
			`BCS_A_PROT: rd_mux = prot_r;
			`BCS_A_CCTL: rd_mux = cctl_r;
			`BCS_A_CVAL: rd_mux = cval_r;
			`BCS_A_STAT: rd_mux = stat;
			`BCS_A_FLT1: rd_mux = flt1;
			`BCS_A_FLT2: rd_mux = flt2;
			default: begin
				if (ADDR_IN[4:2] == 3'(`BCS_A_DLO >> 2))
					rd_mux = duty_lo_r[sub];
				else if (ADDR_IN[4:2] == 3'(`BCS_A_DHI >> 2))
					rd_mux = {4'h0, phase_r[sub], duty_hi_r[sub]};
				else if (ADDR_IN[4:2] == 3'(`BCS_A_DATA >> 2))
					rd_mux = data_r[sub*8 +: 8];
				else
					rd_mux = 8'h00;
			end
		endcase
	end

	// output stage
	wire ov_off = ov && misc_r[`BCS_B_OVACT];
	wire [7:0] ls_drive = ls_en_r & {4'hf, pwm_r};

	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			rdata_r <= 8'h00;
			LOWSIDE_OUT <= 8'h00;
			LAMP_OUT <= 2'h0;
			MR_GATE_OUT <= 1'b0;
			PR_GATE_OUT <= 1'b0;
			SPEED_OE_OUT <= 2'h0;
			SUPPLY_ON_OUT <= 4'h0;
			RETURN_ON_OUT <= 4'h0;
			SENSOR_KIND_OUT <= 1'b0;
			PROTECT_OUT <= 4'h0;
		end else begin
			rdata_r <= RD_IN ? rd_mux : 8'h00;
			LOWSIDE_OUT <= wd_ok ? ls_drive : 8'h00;
			LAMP_OUT <= {misc_r[`BCS_B_LAMP2], misc_r[`BCS_B_LAMP1]};
			MR_GATE_OUT <= misc_r[`BCS_B_MR] && wd_ok && !ov_off;
			PR_GATE_OUT <= misc_r[`BCS_B_PR] && wd_ok;
			SPEED_OE_OUT <= sens_r[1:0];
			SUPPLY_ON_OUT <= sup_r[3:0];
			RETURN_ON_OUT <= sup_r[7:4];
			SENSOR_KIND_OUT <= sens_r[`BCS_B_KIND];
			PROTECT_OUT <= prot_r[3:0];
		end
	end

	assign RDATA_OUT = rdata_r;
endmodule

// File: bcs_defs.svh
`ifndef BCS_DEFS_SVH
`define BCS_DEFS_SVH
// register offsets
`define BCS_A_LS 5'h00
`define BCS_A_MISC 5'h01
`define BCS_A_WD 5'h02
`define BCS_A_SENS 5'h03
`define BCS_A_SUP 5'h04
`define BCS_A_PROT 5'h05
`define BCS_A_CCTL 5'h06
`define BCS_A_CVAL 5'h07
`define BCS_A_STAT 5'h08
`define BCS_A_FLT1 5'h09
`define BCS_A_FLT2 5'h0a
`define BCS_A_DLO 5'h10
`define BCS_A_DHI 5'h14
`define BCS_A_DATA 5'h18
// field positions
`define BCS_B_LAMP1 0
`define BCS_B_LAMP2 1
`define BCS_B_MR 2
`define BCS_B_PR 3
`define BCS_B_WDEN 4
`define BCS_B_OVACT 5
`define BCS_B_SPD1 0
`define BCS_B_SPD2 1
`define BCS_B_KIND 2
`define BCS_B_MRGND 0
`define BCS_B_MROC 1
`define BCS_B_PRGND 2
`define BCS_B_PROC 3
`define BCS_B_CEN 2
`define BCS_B_CCLR 3
`define BCS_B_INRNG 4
`define BCS_B_WDF 5
`define BCS_B_OVF 6
`define BCS_B_CONF 7
// reset values
`define BCS_RST8 8'h00
`define BCS_RST_MISC 8'h00
`define BCS_RST_PROT 8'h00
// timing
`define BCS_CLK_NS 20
`define BCS_MS_NS 1000000
`define BCS_WD_UP_MS 7'h40
`define BCS_WD_LO_MS 7'h20
`define BCS_PH_STEP 2'h0
`endif

// File: bcs_pkg.sv
package bcs_pkg;
	typedef struct packed {
		logic [3:0] batt_short;
		logic [3:0] pin_fault;
		logic [3:0] pin_oc;
		logic [3:0] pulse;
		logic mr_gnd;
		logic mr_oc;
		logic pr_gnd;
		logic pr_oc;
		logic overvolt;
		logic wd_kick;
		logic sel_n;
	} bcs_pins_t;
	typedef struct packed {
		logic [3:0] stb;
		logic [3:0] still;
		logic [31:0] data;
	} bcs_dec_t;
endpackage

// File: bcs_sens_model.sv
module bcs_sens_model (
	// clock and request
	input wire logic clk_in,
	input wire logic go_in,
	input wire logic [1:0] ch_in,
	input wire logic [7:0] val_in,
	input wire logic [3:0] still_in,
	// decoder side
	output bcs_pkg::bcs_dec_t dec_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial dec_out = '0;
	// one strobe per decoded word, data held until next word
	always @(posedge clk_in) begin
		dec_out.stb <= go_in ? (4'h1 << ch_in) : 4'h0;
		dec_out.still <= still_in;
		if (go_in) dec_out.data[{ch_in, 3'h0} +: 8] <= val_in;
	end
endmodule

// File: bcs_top_sva.sv
module bcs_top_chk (
	// watched ports
	input wire logic CLK_IN,
	input wire logic RSTN_IN,
	input wire logic [4:0] ADDR_IN,
	input wire logic [7:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	input wire logic [7:0] RDATA_OUT,
	input wire bcs_pkg::bcs_pins_t PINS_IN,
	input wire logic [7:0] LOWSIDE_OUT,
	input wire logic [1:0] LAMP_OUT,
	input wire logic MR_GATE_OUT,
	input wire logic [1:0] SPEED_OE_OUT,
	input wire logic [3:0] SUPPLY_ON_OUT,
	input wire logic [3:0] RETURN_ON_OUT,
	input wire logic SENSOR_KIND_OUT,
	input wire logic [3:0] PROTECT_OUT
);
	logic [3:0] ov_r;
	logic watchdog_gate_enable_r, ov_act_r;
	wire ov_any = PINS_IN.overvolt | (|ov_r);
	wire wr_misc = WR_IN && ADDR_IN == 5'h01;
	// overvoltage history and last control writes
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			ov_r <= 4'h0;
			watchdog_gate_enable_r <= 1'b0;
			ov_act_r <= 1'b0;
		end else begin
			ov_r <= {ov_r[2:0], PINS_IN.overvolt};
			if (wr_misc) watchdog_gate_enable_r <= WDATA_IN[4];
			if (wr_misc) ov_act_r <= WDATA_IN[5];
		end
	end
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RSTN_IN);
	AST_RD_IDLE: assert property (!RD_IN |=> RDATA_OUT == 8'h00)
		else $error("read data not idle");
	AST_LAMP_WR: assert property (wr_misc |-> ##2 LAMP_OUT == $past(WDATA_IN[1:0], 2))
		else $error("lamp enables not written");
	AST_LAMP_KEEP: assert property (!$stable(LAMP_OUT)
		|-> $past(WR_IN, 2) && $past(ADDR_IN, 2) == 5'h01)
		else $error("lamp enables changed without write");
	AST_MR_FLT: assert property ((PINS_IN.mr_gnd && PROTECT_OUT[0])[*6] |=> !MR_GATE_OUT)
		else $error("main relay not cleared by fault");
	AST_OV_MR: assert property ((PINS_IN.overvolt && ov_act_r)[*6] |=> !MR_GATE_OUT)
		else $error("main relay on in overvoltage");
	AST_OV_CLR: assert property (PINS_IN.overvolt[*6]
		|=> {SPEED_OE_OUT, SUPPLY_ON_OUT, RETURN_ON_OUT} == 10'h000)
		else $error("overvoltage did not clear enables");
	AST_SPD_WR: assert property (WR_IN && ADDR_IN == 5'h03 && !ov_any
		|-> ##2 {SENSOR_KIND_OUT, SPEED_OE_OUT} == $past(WDATA_IN[2:0], 2))
		else $error("speed enables or kind not written");
	AST_SUP_WR: assert property (WR_IN && ADDR_IN == 5'h04 && !ov_any
		|-> ##2 {RETURN_ON_OUT, SUPPLY_ON_OUT} == $past(WDATA_IN, 2))
		else $error("supply or return bits not written");
	AST_PROT_WR: assert property (WR_IN && ADDR_IN == 5'h05
		|-> ##2 PROTECT_OUT == $past(WDATA_IN[3:0], 2))
		else $error("protect enables not written");
	AST_WD_OFF: assert property (WR_IN && ADDR_IN == 5'h00 && !watchdog_gate_enable_r && !wr_misc
		|-> ##2 LOWSIDE_OUT[7:4] == $past(WDATA_IN[7:4], 2))
		else $error("low-side not following enables");
	COV_MISC: cover property (wr_misc);
	COV_OV: cover property (PINS_IN.overvolt[*6]);
	COV_LAMP: cover property (!$stable(LAMP_OUT));
endmodule
bind bcs_top bcs_top_chk u_bcs_top_chk (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .ADDR_IN(ADDR_IN),
	.WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .PINS_IN(PINS_IN),
	.LOWSIDE_OUT(LOWSIDE_OUT), .LAMP_OUT(LAMP_OUT), .MR_GATE_OUT(MR_GATE_OUT),
	.SPEED_OE_OUT(SPEED_OE_OUT), .SUPPLY_ON_OUT(SUPPLY_ON_OUT), .RETURN_ON_OUT(RETURN_ON_OUT),
	.SENSOR_KIND_OUT(SENSOR_KIND_OUT), .PROTECT_OUT(PROTECT_OUT));

// File: testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rstn, wr, rd, go, mr, pr, kind;
	logic [4:0] addr;
	logic [7:0] wdata, val, rdata, ls;
	logic [1:0] ch, lamp, spd;
	logic [3:0] still, sup, ret, prot;
	bcs_pkg::bcs_pins_t pins;
	bcs_pkg::bcs_dec_t dec;
	int err_count = 0;
	int n_compared = 0;
	int hi0 = 0;
	int hi1 = 0;
	int same_n = 0;
	bcs_top #(.MS_CYCLES(10)) u_bcs_top (.CLK_IN(clk), .RSTN_IN(rstn), .ADDR_IN(addr),
		.WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .PINS_IN(pins),
		.DEC_IN(dec), .LOWSIDE_OUT(ls), .LAMP_OUT(lamp), .MR_GATE_OUT(mr), .PR_GATE_OUT(pr),
		.SPEED_OE_OUT(spd), .SUPPLY_ON_OUT(sup), .RETURN_ON_OUT(ret),
		.SENSOR_KIND_OUT(kind), .PROTECT_OUT(prot));
	bcs_sens_model u_bcs_sens_model (.clk_in(clk), .go_in(go), .ch_in(ch), .val_in(val),
		.still_in(still), .dec_out(dec));
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wrr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task rdc(input logic [4:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk($sformatf("reg %h", a), rdata, e);
	endtask
	task print_verdict;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#200000;
		err_count++;
		print_verdict;
	end
	initial begin
		{rstn, wr, rd, go, addr, wdata, val, ch, still} = '0;
		pins = '0;
		pins.sel_n = 1'b1;
		cyc(20);
		rstn <= 1'b1;
		cyc(2);
		chk("outs", {ls, lamp, mr, pr, prot}, 16'h0000);
		rdc(5'h05, 8'h00);
		wrr(5'h05, 8'h01);
		wrr(5'h01, 8'h07);
		wrr(5'h00, 8'hf0);
		cyc(1);
		chk("drv", {ls, lamp, mr}, 16'h0787);
		pins.mr_gnd <= 1'b1;
		cyc(6);
		chk("mrf", {lamp, mr}, 16'h0006);
		rdc(5'h01, 8'h03);
		pins.mr_gnd <= 1'b0;
		cyc(3);
		$display("test relay done");
		wrr(5'h01, 8'h24);
		wrr(5'h03, 8'h07);
		wrr(5'h04, 8'hff);
		cyc(1);
		chk("ovpre", {kind, spd, sup, ret, mr}, 16'h0fff);
		pins.overvolt <= 1'b1;
		cyc(6);
		chk("ov", {kind, spd, sup, ret, mr}, 16'h0800);
		chk("ovls", ls, 8'hf0);
		rdc(5'h01, 8'h24);
		wrr(5'h01, 8'h04);
		cyc(6);
		chk("ovkeep", mr, 1'b1);
		pins.overvolt <= 1'b0;
		$display("test overvoltage done");
		wrr(5'h02, 8'h0f);
		wrr(5'h01, 8'h10);
		cyc(2);
		chk("wdoff", {ls, mr}, 16'h0000);
		pins.wd_kick <= 1'b1;
		cyc(2);
		pins.wd_kick <= 1'b0;
		cyc(58);
		pins.wd_kick <= 1'b1;
		cyc(6);
		chk("wdin", ls, 8'hf0);
		rdc(5'h0a, 8'h10);
		pins.wd_kick <= 1'b0;
		cyc(120);
		chk("wdout", ls, 8'h00);
		rdc(5'h0a, 8'h20);
		rdc(5'h0a, 8'h00);
		wrr(5'h01, 8'h00);
		rdc(5'h0a, 8'h00);
		$display("test watchdog done");
		wrr(5'h06, 8'h06);
		for (int i = 0; i < 8; i++) begin
			pins.pulse <= (i < 5) ? 4'h4 : 4'h1;
			cyc(4);
			pins.pulse <= 4'h0;
			cyc(4);
		end
		pins.sel_n <= 1'b0;
		cyc(4);
		pins.sel_n <= 1'b1;
		cyc(5);
		rdc(5'h07, 8'h05);
		pins.pulse <= 4'h4;
		cyc(4);
		pins.pulse <= 4'h0;
		cyc(4);
		rdc(5'h07, 8'h05);
		wrr(5'h06, 8'h0c);
		wrr(5'h06, 8'h00);
		cyc(1);
		rdc(5'h0a, 8'h80);
		rdc(5'h0a, 8'h00);
		$display("test counter done");
		wrr(5'h06, 8'h06);
		for (int i = 0; i < 256; i++) begin
			if (i == 255)
				rdc(5'h0a, 8'h00);
			pins.pulse <= 4'h4;
			cyc(2);
			pins.pulse <= 4'h0;
			cyc(2);
		end
		rdc(5'h0a, 8'h40);
		rdc(5'h0a, 8'h00);
		$display("test overflow done");
		wrr(5'h10, 8'h00);
		wrr(5'h14, 8'h02);
		wrr(5'h11, 8'h00);
		wrr(5'h15, 8'h01);
		wrr(5'h12, 8'h00);
		wrr(5'h16, 8'h0a);
		wrr(5'h00, 8'h07);
		rdc(5'h16, 8'h0a);
		cyc(1100);
		for (int i = 0; i < 1024; i++) begin
			cyc(1);
			hi0 += ls[0];
			hi1 += ls[1];
			same_n += (ls[0] == ls[2]);
		end
		chk("pwm0", 16'(hi0), 16'h0200);
		chk("pwm1", 16'(hi1), 16'h0100);
		chk("pwmph", 16'(same_n), 16'h0000);
		$display("test pwm done");
		still <= 4'h4;
		ch <= 2'h1;
		val <= 8'h5a;
		go <= 1'b1;
		cyc(1);
		go <= 1'b0;
		cyc(2);
		rdc(5'h08, 8'h42);
		rdc(5'h19, 8'h5a);
		rdc(5'h08, 8'h40);
		pins.batt_short <= 4'h5;
		pins.pin_fault <= 4'h3;
		pins.pin_oc <= 4'hc;
		cyc(4);
		rdc(5'h09, 8'hc3);
		rdc(5'h0a, 8'h05);
		$display("test flags done");
		print_verdict;
	end
endmodule
